// file: hw/ilm_consts.svh
/*
 timing constants of the instruction latency model, in units of one third of a microsecond, except ILM_BASE_NS in nanoseconds.
 assumes inclusion by its bare name from the package and the modules ilm_exec_time and ilm_top.
*/
`ifndef ILM_CONSTS_SVH
`define ILM_CONSTS_SVH
`define ILM_BASE_NS        333
`define ILM_ADJ_STEP       8'h01
`define ILM_BMUL_BASE      8'h48
`define ILM_BMUL_STEP      8'h02
`define ILM_TOFLT_BASE     8'h04
`define ILM_TOFLT_ZERO     8'h01
`define ILM_CSRCH_BASE     8'h04
`define ILM_FDIV_NORM      8'h83
`define ILM_FDIV_OVF       8'h85
`define ILM_FDIV_ABORT     8'h04
`define ILM_FADD_BASE      8'h14
`define ILM_FADD_TERM      8'h07
`define ILM_FADD_DIFF_MAX  12'h023
`define ILM_EXP_SUM_MAX    12'h7ff
`define ILM_FMUL_BASE      8'h3f
`define ILM_FMUL_STEP      8'h02
`define ILM_FMUL_NORM      8'h04
`define ILM_LDFR_ONE       8'h02
`define ILM_LDFR_FOUR12    8'h06
`define ILM_LDFR_THREE16   8'h0c
`define ILM_STFR_12        8'h06
`define ILM_STFR_ONE16     8'h0d
`define ILM_STFR_THREE16   8'h16
`define ILM_SHD_BASE       8'h10
`define ILM_SHD_STEP       8'h02
`define ILM_SHD_MAX_ARITH  6'h0b
`define ILM_SHD_MAX_OTHER  6'h0c
`define ILM_SJMP_PLAIN     8'h10
`define ILM_SJMP_OVL       8'h12
`define ILM_INT_JUMP       8'h15
`define ILM_FETCH          8'h0f
`define ILM_STK_READ       8'h06
`define ILM_STK_WRITE      8'h05
`define ILM_STK_READ_FAST  8'h01
`define ILM_INDIRECT       8'h0d
`define ILM_REPEAT         8'h05
`define ILM_SYL_MEM_RD     8'h10
`define ILM_SYL_MEM_WR     8'h0d
`define ILM_SYL_OPER       8'h04
`define ILM_SYL_OTHER      8'h05
`define ILM_SYL_BR_TAKEN   8'h01
`define ILM_SYL_BR_NOT     8'h02
`define ILM_MAX_ADJ        3'h7
`define ILM_MAX_CSRCH      4'h8
`endif

// file: hw/ilm_pkg.sv
/*
 types of the instruction latency model.
 assumes ilm_consts.svh on the include path.
*/
`include "ilm_consts.svh"
package ilm_pkg;
    typedef enum logic [3:0] {
        ILM_OP_FIELD, ILM_OP_BIN_MUL, ILM_OP_BIN_DIV, ILM_OP_TO_FLOAT, ILM_OP_CHAR_SRCH,
        ILM_OP_FLT_DIV, ILM_OP_FADD, ILM_OP_FMUL, ILM_OP_LOADF, ILM_OP_STOREF,
        ILM_OP_SHD, ILM_OP_SUB_JUMP, ILM_OP_INTJ, ILM_OP_FIXED
    } ilm_op_t;

    typedef struct packed {
        ilm_op_t     op;
        logic [7:0]  base;       // base time for field, binary divide and fixed classes
        logic [5:0]  count;      // adjustments, shifts, positions, ones
        logic [5:0]  count2;     // normalising shifts for float add
        logic [1:0]  variant;    // register group or divide outcome
        logic        flag;       // zero, arith shift, overlap, norm
        logic        float_term; // float add early termination
    } ilm_instr_t;

    typedef struct packed {
        logic [2:0] oper_syl;
        logic [2:0] mem_rd_syl;
        logic [2:0] mem_wr_syl;
        logic [2:0] other_syl;
        logic [1:0] br_taken;
        logic [1:0] br_not;
        logic [1:0] stk_rd;
        logic [1:0] stk_wr;
        logic [2:0] ind_levels;
        logic       word_fetch;
    } ilm_ovh_t;
endpackage

// file: hw/ilm_exec_time.sv
/*
 combinational execution-time table: converts one instruction description into base periods.
 assumes descriptor fields come unregistered through the sequencer's INSTR input, sampled on the START edge.
*/
`timescale 1ns/1ns
`include "ilm_consts.svh"
module ilm_exec_time
    import ilm_pkg::*;
(
    input  wire ilm_instr_t  ins,    // instruction description
    output logic [7:0]       ticks   // execution time in base periods
);
    function automatic logic [7:0] extra(input logic [5:0] n, input logic [7:0] step);
        extra = (n == 6'h00) ? 8'h00 : 8'((n - 6'h01) * step);
    endfunction

    wire [5:0] shd_cap  = ins.flag ? `ILM_SHD_MAX_ARITH : `ILM_SHD_MAX_OTHER;
    wire [5:0] shd_n    = (ins.count > shd_cap) ? shd_cap : ins.count;
    wire [5:0] adj_n    = (ins.count > 6'(`ILM_MAX_ADJ)) ? 6'(`ILM_MAX_ADJ) : ins.count;
    wire [5:0] cse_n    = (ins.count > 6'(`ILM_MAX_CSRCH)) ? 6'(`ILM_MAX_CSRCH) :
                          ((ins.count == 6'h00) ? 6'h01 : ins.count);

    always_comb
    begin
        unique case (ins.op)
            ILM_OP_FIELD:     ticks = 8'(ins.base + extra(adj_n, `ILM_ADJ_STEP));
            ILM_OP_BIN_MUL:   ticks = 8'(`ILM_BMUL_BASE + ins.count * `ILM_BMUL_STEP);
            ILM_OP_BIN_DIV:   ticks = ins.base;
            ILM_OP_TO_FLOAT:  ticks = ins.flag ? `ILM_TOFLT_ZERO :
                                      8'(`ILM_TOFLT_BASE + ins.count);
            ILM_OP_CHAR_SRCH: ticks = 8'(`ILM_CSRCH_BASE + cse_n);
            ILM_OP_FLT_DIV:   ticks = (ins.variant == 2'h2) ? `ILM_FDIV_ABORT :
                                      ((ins.variant == 2'h1) ? `ILM_FDIV_OVF : `ILM_FDIV_NORM);
            ILM_OP_FADD:      ticks = ins.float_term ? `ILM_FADD_TERM :
                                      8'(`ILM_FADD_BASE + ins.count + ins.count2);
            ILM_OP_FMUL:      ticks = 8'(`ILM_FMUL_BASE + ins.count * `ILM_FMUL_STEP
                                      + (ins.flag ? `ILM_FMUL_NORM : 8'h00));
            ILM_OP_LOADF:     ticks = (ins.variant == 2'h0) ? `ILM_LDFR_ONE :
                                      ((ins.variant == 2'h1) ? `ILM_LDFR_FOUR12 : `ILM_LDFR_THREE16);
            ILM_OP_STOREF:    ticks = (ins.variant == 2'h0) ? `ILM_STFR_12 :
                                      ((ins.variant == 2'h1) ? `ILM_STFR_ONE16 : `ILM_STFR_THREE16);
            ILM_OP_SHD:       ticks = 8'(`ILM_SHD_BASE + extra(shd_n, `ILM_SHD_STEP));
            ILM_OP_SUB_JUMP:  ticks = ins.flag ? `ILM_SJMP_OVL : `ILM_SJMP_PLAIN;
            ILM_OP_INTJ:      ticks = `ILM_INT_JUMP;
            ILM_OP_FIXED:     ticks = ins.base;
            default:          ticks = 8'h00;
        endcase
    end
endmodule

// file: hw/ilm_top.sv
/*
 instruction latency sequencer: counts the run time of each instruction in base periods.
 assumes the processor's control logic presents one instruction with its overheads per START pulse.
*/
// Function
// - field instruction: base plus one period per adjustment beyond first, up to seven
// - binary multiply: 72 periods plus two per counted multiplier one-bit
// - convert to float: four periods plus one per shift; one if zero
// - character search: four periods plus one per position, one to eight
// - float divide: 131 normal, 133 corrected overflow, 4 on exponent fault
// - float add/subtract: 20 periods plus one per alignment and normalise shift
// - float add/subtract exits in 7 periods on exponent-sum overflow
// - float multiply: 63 plus two per counted one, plus four if normalising
// - fast register load: 2, 6 or 12 periods by group
// - fast register store: 6, 13 or 22 periods by group
// - double shift: 16 plus two per extra shift, capped at 11 or 12
// - subroutine jump: 16 periods, or 18 after an overlapped fetch
// - automatic interrupt jump: 21 periods
// - word fetch 15 periods; hidden when fetched in background
// - background fetch allowed for float ops, binary divide and multiply
// - stack read 6, write 5, read after previous write 1
// - each indirect level 13 periods, first pass only
// - repeat iterations after the first add 5 periods each
// - syllables: memory read 16, memory write 13, operator 4, other 5
// - branch syllable 1 if taken, 2 if not
`timescale 1ns/1ns
`include "ilm_consts.svh"
module ilm_top
    import ilm_pkg::*;
#(
    parameter int BASE_NS = `ILM_BASE_NS,   // base period length
    parameter int CLK_NS  = 10              // processor clock period
)
(
    input  wire logic       CLK,        // processor clock
    input  wire logic       RESET_N,    // asynchronous reset, active low
    input  wire logic       START,      // one-cycle request with descriptors
    input  wire ilm_instr_t INSTR,      // instruction description
    input  wire ilm_ovh_t   OVH,        // syllable and access overheads
    input  wire logic [5:0] REPEATS,    // iterations of a repeated instruction, 0 = single
    output logic            BUSY,       // timing in progress
    output logic            DONE,       // one-cycle pulse at the end
    output logic [15:0]     TOTAL,      // total base periods of the last instruction
    output logic            TICK        // base period enable pulse
);
    localparam int TICK_CYC = (BASE_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [1:0] {ILM_IDLE, ILM_RUN, ILM_END} ilm_state_t;

    logic        rst_m_q, rst_n_q;
    ilm_state_t  state_q, state_d;
    logic [6:0]  div_q;
    logic [15:0] remain_q, total_q;
    logic        last_wr_q;
    logic [7:0]  exec_ticks;

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            rst_m_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_m_q <= 1'b1;
            rst_n_q <= rst_m_q;
        end
    end

    ilm_exec_time u_exec (
        .ins   (INSTR),
        .ticks (exec_ticks)
    );

    function automatic logic [15:0] mul16(input logic [5:0] n, input logic [7:0] c);
        mul16 = 16'(n) * 16'(c);
    endfunction

    // background fetch only hides the cost for float ops, binary divide and binary multiply
    wire ovl_ok = (INSTR.op == ILM_OP_FADD) || (INSTR.op == ILM_OP_FMUL) ||
                  (INSTR.op == ILM_OP_FLT_DIV) || (INSTR.op == ILM_OP_TO_FLOAT) ||
                  (INSTR.op == ILM_OP_BIN_DIV) || (INSTR.op == ILM_OP_BIN_MUL);
    wire       hide_fetch = OVH.word_fetch && ovl_ok;
    wire [5:0] iters      = (REPEATS == 6'h00) ? 6'h01 : REPEATS;
    wire [5:0] extra_it   = 6'(iters - 6'h01);

    // a stack read following the previous write costs the fast figure once
    wire [7:0] rd_first = last_wr_q ? `ILM_STK_READ_FAST : `ILM_STK_READ;
    wire [15:0] stk_cost = (OVH.stk_rd == 2'h0) ? 16'h0000 :
                           16'(rd_first) + mul16(6'(OVH.stk_rd - 2'h1), `ILM_STK_READ)
                         ;
    wire [15:0] stk_wr_cost = mul16(6'(OVH.stk_wr), `ILM_STK_WRITE);

    wire [15:0] syl_cost = mul16(6'(OVH.oper_syl),   `ILM_SYL_OPER)   +
                           mul16(6'(OVH.mem_rd_syl), `ILM_SYL_MEM_RD) +
                           mul16(6'(OVH.mem_wr_syl), `ILM_SYL_MEM_WR) +
                           mul16(6'(OVH.other_syl),  `ILM_SYL_OTHER);
    wire [15:0] br_cost  = mul16(6'(OVH.br_taken), `ILM_SYL_BR_TAKEN) +
                           mul16(6'(OVH.br_not),   `ILM_SYL_BR_NOT);
    wire [15:0] ind_cost = mul16(6'(OVH.ind_levels), `ILM_INDIRECT);
    wire [15:0] rep_cost = mul16(extra_it, `ILM_REPEAT);
    wire [15:0] exe_cost = mul16(iters, exec_ticks);
    wire [15:0] fet_cost = (OVH.word_fetch && !hide_fetch) ? 16'(`ILM_FETCH) : 16'h0000;

    wire [15:0] sum = 16'(exe_cost + stk_cost + stk_wr_cost + syl_cost + br_cost +
                          ind_cost + rep_cost + fet_cost);

    wire tick_now = (div_q == 7'(TICK_CYC - 1));

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ILM_IDLE: if (START) state_d = (sum == 16'h0000) ? ILM_END : ILM_RUN;
            ILM_RUN:  if (tick_now && remain_q == 16'h0001) state_d = ILM_END;
            ILM_END:  state_d = ILM_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            state_q   <= ILM_IDLE;
            div_q     <= 7'h00;
            remain_q  <= 16'h0000;
            total_q   <= 16'h0000;
            last_wr_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            div_q   <= (tick_now || state_q != ILM_RUN) ? 7'h00 : 7'(div_q + 7'h01);
            if (state_q == ILM_IDLE && START)
            begin
                remain_q  <= sum;
                total_q   <= sum;
                last_wr_q <= (OVH.stk_wr != 2'h0);
            end
            else if (state_q == ILM_RUN && tick_now)
                remain_q <= 16'(remain_q - 16'h0001);
        end
    end

    assign BUSY  = (state_q != ILM_IDLE);
    assign DONE  = (state_q == ILM_END);
    assign TOTAL = total_q;
    assign TICK  = (state_q == ILM_RUN) && tick_now;
endmodule

// file: sim/ilm_top_assertions.sv
/*
 checker for the latency sequencer: pulse shapes, tick spacing and a few fixed totals.
 assumes a single clock domain and the 34-clock base period of the default parameters.
*/
`timescale 1ns/1ns
module ilm_top_chk
    import ilm_pkg::*;
(
    input wire logic        CLK,     // processor clock
    input wire logic        RESET_N, // async reset, active low
    input wire logic        START,   // request pulse
    input wire ilm_instr_t  INSTR,   // instruction description
    input wire ilm_ovh_t    OVH,     // overheads
    input wire logic [5:0]  REPEATS, // iterations
    input wire logic        BUSY,    // timing in progress
    input wire logic        DONE,    // end pulse
    input wire logic [15:0] TOTAL,   // total base periods
    input wire logic        TICK     // base period pulse
);
    logic [5:0]  gap_q;
    logic        seen_q;
    logic [15:0] ticks_q;
    // tick bookkeeping is cleared at the end pulse, so each instruction is judged alone
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            gap_q   <= '0;
            seen_q  <= 1'b0;
            ticks_q <= '0;
        end
        else if (DONE)
        begin
            gap_q   <= '0;
            seen_q  <= 1'b0;
            ticks_q <= '0;
        end
        else
        begin
            gap_q   <= TICK ? 6'h00 : gap_q + 6'h01;
            seen_q  <= seen_q | TICK;
            ticks_q <= ticks_q + {15'h0000, TICK};
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    chk_done_pulse: assert property (DONE |=> !DONE) else $error("done wider than one cycle");
    chk_busy_start: assert property (START && !BUSY |=> BUSY) else $error("busy not raised");
    chk_busy_end: assert property (DONE |=> !BUSY) else $error("busy held after done");
    chk_total_hold: assert property (BUSY && !DONE |=> $stable(TOTAL)) else $error("total moved");
    chk_tick_gap: assert property (TICK && seen_q |-> gap_q == 6'h21) else $error("tick spacing");
    chk_tick_count: assert property (DONE |-> ticks_q == TOTAL) else $error("tick count");
    chk_tick_busy: assert property (TICK |-> BUSY) else $error("tick while idle");
    chk_fdiv_fault: assert property (START && !BUSY && INSTR.op == ILM_OP_FLT_DIV && INSTR.variant == 2'h2
        && OVH == '0 && REPEATS <= 6'h01 |=> TOTAL == 16'h0004) else $error("divide abort time");
    chk_intj_time: assert property (START && !BUSY && INSTR.op == ILM_OP_INTJ && OVH == '0
        && REPEATS <= 6'h01 |=> TOTAL == 16'h0015) else $error("interrupt jump time");
    chk_sjmp_time: assert property (START && !BUSY && INSTR.op == ILM_OP_SUB_JUMP && OVH == '0 && REPEATS <= 6'h01
        |=> TOTAL == ($past(INSTR.flag) ? 16'h0012 : 16'h0010)) else $error("subroutine jump time");
endmodule
bind ilm_top ilm_top_chk u_chk (.CLK(CLK), .RESET_N(RESET_N), .START(START), .INSTR(INSTR), .OVH(OVH),
    .REPEATS(REPEATS), .BUSY(BUSY), .DONE(DONE), .TOTAL(TOTAL), .TICK(TICK));

// file: sim/tb_top.sv
/*
 self-checking bench for the latency sequencer: one task per scenario, totals and latencies compared.
 assumes default parameters, so one base period is 34 clocks.
*/
`timescale 1ns/1ns
module tb_top
    import ilm_pkg::*;
;
    logic        CLK = 1'b0;
    logic        RESET_N = 1'b0;
    logic        START = 1'b0;
    ilm_instr_t  INSTR = '0;
    ilm_ovh_t    OVH = '0;
    logic [5:0]  REPEATS = '0;
    logic        BUSY, DONE, TICK;
    logic [15:0] TOTAL;
    int          err_count = 0;
    int          samples_checked = 0;
    always #5 CLK = ~CLK;
    ilm_top dut (.CLK(CLK), .RESET_N(RESET_N), .START(START), .INSTR(INSTR), .OVH(OVH), .REPEATS(REPEATS),
        .BUSY(BUSY), .DONE(DONE), .TOTAL(TOTAL), .TICK(TICK));
    function automatic ilm_instr_t mk(ilm_op_t op, logic [7:0] b, logic [5:0] c, logic [5:0] c2,
        logic [1:0] v, logic f, logic t);
        mk = '{op, b, c, c2, v, f, t};
    endfunction
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // entered just after an edge; leaves in the cycle after done, where the next start is legal
    task automatic issue(input ilm_instr_t i, input ilm_ovh_t o, input logic [5:0] r, input logic [15:0] exp);
        int n;
        n = 0;
        INSTR = i; OVH = o; REPEATS = r; START = 1'b1;
        @(posedge CLK); #1;
        START = 1'b0;
        // total is loaded at the taking edge; done shows 34 clocks per period after that edge
        check("total", TOTAL, exp);
        while (DONE !== 1'b1 && n < 6000)
        begin
            @(posedge CLK); #1;
            n++;
        end
        check("latency", n[15:0], 16'(exp * 16'h0022));
        @(posedge CLK); #1;
        check("busy", {15'h0000, BUSY}, 16'h0000);
    endtask
    task automatic t_exec;
        issue(mk(ILM_OP_FIELD, 8'h09, 6'h00, 6'h00, 2'h0, 1'b0, 1'b0), '0, 6'h00, 16'h0009);
        issue(mk(ILM_OP_FIELD, 8'h09, 6'h01, 6'h00, 2'h0, 1'b0, 1'b0), '0, 6'h00, 16'h0009);
        issue(mk(ILM_OP_FIELD, 8'h09, 6'h07, 6'h00, 2'h0, 1'b0, 1'b0), '0, 6'h00, 16'h000f);
        issue(mk(ILM_OP_BIN_MUL, 8'h00, 6'h03, 6'h00, 2'h0, 1'b0, 1'b0), '0, 6'h00, 16'h004e);
        issue(mk(ILM_OP_TO_FLOAT, 8'h00, 6'h00, 6'h00, 2'h0, 1'b1, 1'b0), '0, 6'h00, 16'h0001);
        issue(mk(ILM_OP_TO_FLOAT, 8'h00, 6'h05, 6'h00, 2'h0, 1'b0, 1'b0), '0, 6'h00, 16'h0009);
        issue(mk(ILM_OP_CHAR_SRCH, 8'h00, 6'h01, 6'h00, 2'h0, 1'b0, 1'b0), '0, 6'h00, 16'h0005);
        issue(mk(ILM_OP_CHAR_SRCH, 8'h00, 6'h08, 6'h00, 2'h0, 1'b0, 1'b0), '0, 6'h00, 16'h000c);
        issue(mk(ILM_OP_FLT_DIV, 8'h00, 6'h00, 6'h00, 2'h0, 1'b0, 1'b0), '0, 6'h00, 16'h0083);
        issue(mk(ILM_OP_FLT_DIV, 8'h00, 6'h00, 6'h00, 2'h1, 1'b0, 1'b0), '0, 6'h00, 16'h0085);
        issue(mk(ILM_OP_FLT_DIV, 8'h00, 6'h00, 6'h00, 2'h2, 1'b0, 1'b0), '0, 6'h00, 16'h0004);
        issue(mk(ILM_OP_FADD, 8'h00, 6'h02, 6'h03, 2'h0, 1'b0, 1'b0), '0, 6'h00, 16'h0019);
        issue(mk(ILM_OP_FADD, 8'h00, 6'h02, 6'h03, 2'h0, 1'b0, 1'b1), '0, 6'h00, 16'h0007);
        issue(mk(ILM_OP_FMUL, 8'h00, 6'h04, 6'h00, 2'h0, 1'b0, 1'b0), '0, 6'h00, 16'h0047);
        issue(mk(ILM_OP_FMUL, 8'h00, 6'h00, 6'h00, 2'h0, 1'b1, 1'b0), '0, 6'h00, 16'h0043);
        issue(mk(ILM_OP_SHD, 8'h00, 6'h01, 6'h00, 2'h0, 1'b0, 1'b0), '0, 6'h00, 16'h0010);
        issue(mk(ILM_OP_SHD, 8'h00, 6'h0c, 6'h00, 2'h0, 1'b0, 1'b0), '0, 6'h00, 16'h0026);
        issue(mk(ILM_OP_SHD, 8'h00, 6'h0b, 6'h00, 2'h0, 1'b1, 1'b0), '0, 6'h00, 16'h0024);
        // counts past the cap must be clipped to 12 and 11 shifts
        issue(mk(ILM_OP_SHD, 8'h00, 6'h0f, 6'h00, 2'h0, 1'b0, 1'b0), '0, 6'h00, 16'h0026);
        issue(mk(ILM_OP_SHD, 8'h00, 6'h0f, 6'h00, 2'h0, 1'b1, 1'b0), '0, 6'h00, 16'h0024);
        issue(mk(ILM_OP_SUB_JUMP, 8'h00, 6'h00, 6'h00, 2'h0, 1'b0, 1'b0), '0, 6'h00, 16'h0010);
        issue(mk(ILM_OP_SUB_JUMP, 8'h00, 6'h00, 6'h00, 2'h0, 1'b1, 1'b0), '0, 6'h00, 16'h0012);
        // a zero-time instruction goes straight to the end pulse
        issue(mk(ILM_OP_FIXED, 8'h00, 6'h00, 6'h00, 2'h0, 1'b0, 1'b0), '0, 6'h00, 16'h0000);
        issue(mk(ILM_OP_INTJ, 8'h00, 6'h00, 6'h00, 2'h0, 1'b0, 1'b0), '0, 6'h00, 16'h0015);
    endtask
    task automatic t_fast_regs;
        logic [15:0] ld [3];
        logic [15:0] st [3];
        ld = '{16'h0002, 16'h0006, 16'h000c};
        st = '{16'h0006, 16'h000d, 16'h0016};
        for (int k = 0; k < 3; k++)
        begin
            issue(mk(ILM_OP_LOADF, 8'h00, 6'h00, 6'h00, k[1:0], 1'b0, 1'b0), '0, 6'h00, ld[k]);
            issue(mk(ILM_OP_STOREF, 8'h00, 6'h00, 6'h00, k[1:0], 1'b0, 1'b0), '0, 6'h00, st[k]);
        end
    endtask
    task automatic t_overheads;
        ilm_instr_t nul;
        ilm_ovh_t   o;
        nul = mk(ILM_OP_FIXED, 8'h00, 6'h00, 6'h00, 2'h0, 1'b0, 1'b0);
        o = '0; o.oper_syl = 3'h1; issue(nul, o, 6'h00, 16'h0004);
        o = '0; o.mem_rd_syl = 3'h1; issue(nul, o, 6'h00, 16'h0010);
        o = '0; o.mem_wr_syl = 3'h1; issue(nul, o, 6'h00, 16'h000d);
        o = '0; o.other_syl = 3'h1; issue(nul, o, 6'h00, 16'h0005);
        o = '0; o.br_taken = 2'h1; issue(nul, o, 6'h00, 16'h0001);
        o = '0; o.br_not = 2'h1; issue(nul, o, 6'h00, 16'h0002);
        o = '0; o.word_fetch = 1'b1; issue(nul, o, 6'h00, 16'h000f);
        issue(mk(ILM_OP_FMUL, 8'h00, 6'h00, 6'h00, 2'h0, 1'b0, 1'b0), o, 6'h00, 16'h003f);
        issue(mk(ILM_OP_BIN_MUL, 8'h00, 6'h00, 6'h00, 2'h0, 1'b0, 1'b0), o, 6'h00, 16'h0048);
        issue(mk(ILM_OP_BIN_DIV, 8'ha1, 6'h00, 6'h00, 2'h0, 1'b0, 1'b0), o, 6'h00, 16'h00a1);
        o = '0; o.stk_wr = 2'h1; issue(nul, o, 6'h00, 16'h0005);
        o = '0; o.stk_rd = 2'h1; issue(nul, o, 6'h00, 16'h0001);
        issue(nul, o, 6'h00, 16'h0006);
        issue(mk(ILM_OP_FIXED, 8'h03, 6'h00, 6'h00, 2'h0, 1'b0, 1'b0), '0, 6'h03, 16'h0013);
        o = '0; o.ind_levels = 3'h1; issue(nul, o, 6'h03, 16'h0017);
    endtask
    // a start while busy must neither reload the total nor stretch the run
    task automatic t_refuse;
        int n;
        n = 0;
        INSTR = mk(ILM_OP_FLT_DIV, 8'h00, 6'h00, 6'h00, 2'h0, 1'b0, 1'b0);
        OVH = '0;
        REPEATS = 6'h00;
        START = 1'b1;
        @(posedge CLK); #1;
        START = 1'b0;
        repeat (40) @(posedge CLK);
        #1;
        INSTR = mk(ILM_OP_FIXED, 8'h05, 6'h00, 6'h00, 2'h0, 1'b0, 1'b0); START = 1'b1;
        @(posedge CLK); #1;
        START = 1'b0;
        check("total", TOTAL, 16'h0083);
        while (DONE !== 1'b1 && n < 5000)
        begin
            @(posedge CLK); #1;
            n++;
        end
        // the refused start came 41 edges after the taking edge
        check("latency", n[15:0], 16'(16'h0083 * 16'h0022 - 16'h0029));
        @(posedge CLK); #1;
        check("busy", {15'h0000, BUSY}, 16'h0000);
    endtask
    task automatic report_and_stop;
        $display("errors %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        #800000;
        err_count++;
        report_and_stop();
    end
    initial
    begin
        repeat (3) @(posedge CLK);
        #1 RESET_N = 1'b1;
        repeat (6) @(posedge CLK);
        #1;
        t_exec();
        t_fast_regs();
        t_overheads();
        t_refuse();
        report_and_stop();
    end
endmodule
